// [core/aivf_mem.sv]
`timescale 1ns/100ps
module aivf_mem #(
  parameter int AW = 4,
  parameter int DW = 16
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // no reset: a channel never converted reads whatever the array holds
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

// [core/aivf_pkg.sv]
package aivf_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_SCAN     = 8'h04;
  localparam logic [7:0] OFS_PEND     = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0c;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam logic [7:0] OFS_DATA     = 8'h40;
  localparam logic [7:0] DATA_MASK    = 8'hc3;
  // control fields
  localparam int CTRL_VARIANT_BIT = 0;
  localparam int CTRL_FMT_LSB     = 1;
  localparam int CTRL_UNIPOLAR    = 3;
  localparam int CTRL_SINGLE_BIT  = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam int SCAN_START_BIT   = 8;
  // measured-value word layout
  localparam int W_OVF  = 0;
  localparam int W_WIRE = 1;
  localparam int W_BUSY = 2;
  localparam int W_SIGN = 15;
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVF  = 1;
  localparam int IRQ_WIRE = 2;
  localparam int IRQ_SCAN = 3;
  localparam int IRQ_W    = 4;
  // channels and value limits in units
  localparam int CH_N  = 16;
  localparam int CH_W  = 4;
  localparam int VAL_W = 14;
  localparam logic signed [13:0] LIM_FULL   = 14'sh0fff;
  localparam logic signed [13:0] LIM_NOM_HI = 14'sh07ff;
  localparam logic signed [13:0] LIM_NOM_LO = -14'sh0800;
  localparam logic signed [13:0] LIM_ZERO   = 14'sh0000;
  localparam logic signed [13:0] BIN_OFFSET = 14'sh0800;

  typedef enum logic [1:0] {
    AIVF_FMT_TWOS = 2'b00,
    AIVF_FMT_SIGN = 2'b01,
    AIVF_FMT_BIN  = 2'b10
  } aivf_fmt_e;

  typedef enum logic [0:0] {
    AIVF_VAR_OVR  = 1'b0,
    AIVF_VAR_NOVR = 1'b1
  } aivf_var_e;
endpackage

// [core/aivf_top.sv]
`timescale 1ns/100ps
module aivf_top
  import aivf_pkg::*;
(
  input  wire logic                          SYS_CLK_I,
  input  wire logic                          RSTN_I,
  input  wire logic                          PSEL_I,
  input  wire logic                          PENABLE_I,
  input  wire logic                          PWRITE_I,
  input  wire logic [7:0]                    PADDR_I,
  input  wire logic [31:0]                   PWDATA_I,
  output logic      [31:0]                   PRDATA_O,
  output logic                               PREADY_O,
  output logic                               PSLVERR_O,
  input  wire logic                          CONV_DONE_I,
  input  wire logic [aivf_pkg::CH_W-1:0]     CONV_CH_I,
  input  wire logic signed [aivf_pkg::VAL_W-1:0] CONV_VALUE_I,
  input  wire logic                          CONV_WIRE_BREAK_I,
  output logic                               SCAN_REQ_O,
  output logic      [aivf_pkg::CH_W-1:0]     SCAN_CH_O,
  output logic                               IRQ_O
);
  import aivf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [4:0]        ctrl;
  logic [CH_N-1:0]   pend;
  logic [IRQ_W-1:0]  int_stat;
  logic [IRQ_W-1:0]  int_mask;
  logic [15:0]       mem_rdata;

  wire       variant_novr = ctrl[CTRL_VARIANT_BIT];
  // reserved format code 11 codes as two's complement on both variants
  wire [1:0] fmt          = (ctrl[CTRL_FMT_LSB +: 2] == 2'b11) ? AIVF_FMT_TWOS : ctrl[CTRL_FMT_LSB +: 2];
  wire       unipolar     = ctrl[CTRL_UNIPOLAR];
  wire       single_mode  = ctrl[CTRL_SINGLE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire apb_acc   = PSEL_I && PENABLE_I && !PREADY_O;
  wire apb_done  = PSEL_I && PENABLE_I && PREADY_O;
  wire apb_wr    = apb_done && PWRITE_I;
  wire hit_ctrl  = (PADDR_I == OFS_CTRL);
  wire hit_scan  = (PADDR_I == OFS_SCAN);
  wire hit_pend  = (PADDR_I == OFS_PEND);
  wire hit_stat  = (PADDR_I == OFS_INT_STAT);
  wire hit_mask  = (PADDR_I == OFS_INT_MASK);
  wire hit_data  = ((PADDR_I & DATA_MASK) == OFS_DATA);
  wire hit_any   = hit_ctrl || hit_scan || hit_pend || hit_stat || hit_mask || hit_data;
  // data window is read only
  wire bad_acc   = !hit_any || (PWRITE_I && (hit_pend || hit_data));
  wire [CH_W-1:0] rd_ch = PADDR_I[2 +: CH_W];

  ////////////////////////////////////////////////////////////////////////////
  // value coding
  logic signed [13:0] lim_hi;
  logic signed [13:0] lim_lo;
  logic signed [13:0] clamped;
  logic signed [13:0] absval;
  logic signed [13:0] binval;
  logic               ovf;
  logic [15:0]        wr_word;

  always_comb begin
    // coding limits per variant and format
    if (unipolar) begin
      lim_hi = LIM_FULL;
      lim_lo = LIM_ZERO;
    end else if (fmt == AIVF_FMT_BIN) begin
      lim_hi = LIM_NOM_HI;
      lim_lo = LIM_NOM_LO;
    end else if (variant_novr) begin
      // no overrange region on this variant
      lim_hi = LIM_NOM_HI;
      lim_lo = (fmt == AIVF_FMT_SIGN) ? -LIM_NOM_HI : LIM_NOM_LO;
    end else begin
      lim_hi = LIM_FULL;
      lim_lo = -LIM_FULL;
    end
    ovf     = (CONV_VALUE_I > lim_hi) || (CONV_VALUE_I < lim_lo);
    clamped = ovf ? ((CONV_VALUE_I > lim_hi) ? lim_hi : lim_lo) : CONV_VALUE_I;
    absval  = clamped[13] ? -clamped : clamped;
    binval  = clamped + BIN_OFFSET;
    wr_word = 16'h0000;
    if (unipolar) begin
      wr_word[14:3] = clamped[11:0];
    end else begin
      case (fmt)
        AIVF_FMT_TWOS: begin
          if (variant_novr) begin
            wr_word[W_SIGN] = clamped[13];
            wr_word[13:3]   = clamped[10:0];
          end else begin
            wr_word[15:3]   = clamped[12:0];
          end
        end
        AIVF_FMT_SIGN: begin
          wr_word[W_SIGN] = clamped[13];
          wr_word[14:3]   = absval[11:0];
        end
        AIVF_FMT_BIN: begin
          wr_word[14:3]   = binval[11:0];
        end
        default: begin
          wr_word[15:3]   = clamped[12:0];
        end
      endcase
    end
    // stored low bits carry flags only; busy is merged live on read
    wr_word[W_OVF]  = ovf;
    wr_word[W_WIRE] = CONV_WIRE_BREAK_I;
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel memory: flags and value in one write
  aivf_mem #(.AW(CH_W), .DW(16)) u_mem (
    .clk_i   (SYS_CLK_I),
    .we_i    (CONV_DONE_I),
    .waddr_i (CONV_CH_I),
    .wdata_i (wr_word),
    .raddr_i (rd_ch),
    .rdata_o (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control, single scan, interrupts
  wire       scan_start = apb_wr && hit_scan && PWDATA_I[SCAN_START_BIT] && single_mode && !variant_novr;
  wire [CH_W-1:0] scan_ch = PWDATA_I[CH_W-1:0];
  wire [CH_N-1:0] pend_set = scan_start ? (16'h0001 << scan_ch) : 16'h0000;
  wire [CH_N-1:0] pend_clr = CONV_DONE_I ? (16'h0001 << CONV_CH_I) : 16'h0000;
  // a new request wins over the clear of the same channel
  wire [CH_N-1:0] next_pend = variant_novr ? 16'h0000 : ((pend & ~pend_clr) | pend_set);

  wire [IRQ_W-1:0] irq_ev;
  assign irq_ev[IRQ_DONE] = CONV_DONE_I;
  assign irq_ev[IRQ_OVF]  = CONV_DONE_I && ovf;
  assign irq_ev[IRQ_WIRE] = CONV_DONE_I && CONV_WIRE_BREAK_I;
  assign irq_ev[IRQ_SCAN] = |(pend & pend_clr);
  wire [IRQ_W-1:0] stat_clr      = (apb_wr && hit_stat) ? PWDATA_I[IRQ_W-1:0] : 4'h0;
  // set wins over a write-one clear in the same cycle
  wire [IRQ_W-1:0] next_int_stat = (int_stat & ~stat_clr) | irq_ev;
  // mask write reaches the pin at the same edge as the mask register
  wire [IRQ_W-1:0] next_int_mask = (apb_wr && hit_mask) ? PWDATA_I[IRQ_W-1:0] : int_mask;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      ctrl     <= CTRL_RESET;
      pend     <= '0;
      int_stat <= '0;
      int_mask <= '0;
    end else begin
      if (apb_wr && hit_ctrl) begin
        ctrl <= PWDATA_I[4:0];
      end
      int_mask <= next_int_mask;
      pend     <= next_pend;
      int_stat <= next_int_stat;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      SCAN_REQ_O <= 1'b0;
      SCAN_CH_O  <= '0;
      IRQ_O      <= 1'b0;
    end else begin
      SCAN_REQ_O <= scan_start;
      SCAN_CH_O  <= scan_start ? scan_ch : SCAN_CH_O;
      IRQ_O      <= |(next_int_stat & next_int_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, read data registered
  wire [15:0] data_word = mem_rdata | ({15'h0000, pend[rd_ch]} << W_BUSY);
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[4:0] = ctrl;
    end else if (hit_pend) begin
      rd_mux[CH_N-1:0] = pend;
    end else if (hit_stat) begin
      rd_mux[IRQ_W-1:0] = int_stat;
    end else if (hit_mask) begin
      rd_mux[IRQ_W-1:0] = int_mask;
    end else if (hit_data) begin
      rd_mux[15:0] = data_word;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
    end else begin
      PREADY_O  <= apb_acc;
      PSLVERR_O <= apb_acc && bad_acc;
      PRDATA_O  <= (apb_acc && !PWRITE_I && !bad_acc) ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);

  low_bits_status_a: assert property (CONV_DONE_I |-> (wr_word[W_BUSY] == 1'b0 && wr_word[W_OVF] == (clamped != CONV_VALUE_I)))
    else $error("stored low bits carry more than status");
  wire_flag_a: assert property (CONV_DONE_I |-> wr_word[W_WIRE] == CONV_WIRE_BREAK_I)
    else $error("wire flag does not follow wire break");
  pend_clear_a: assert property ((CONV_DONE_I && !scan_start) |=> !pend[$past(CONV_CH_I)])
    else $error("pending bit not cleared by conversion");
  novr_no_pend_a: assert property (variant_novr |=> pend == '0)
    else $error("pending bit set on no-overrange variant");
  novr_bit14_a: assert property ((CONV_DONE_I && variant_novr && !unipolar && fmt != AIVF_FMT_BIN)
                                 |-> wr_word[14] == 1'b0)
    else $error("bit 14 used on no-overrange variant");
  ovr_saturate_a: assert property ((CONV_DONE_I && !variant_novr && !unipolar && fmt == AIVF_FMT_TWOS
                                   && CONV_VALUE_I > LIM_FULL) |-> (wr_word[15:3] == 13'h0fff && wr_word[W_OVF]))
    else $error("positive saturation code wrong");
  novr_sign_a: assert property ((CONV_DONE_I && variant_novr && !unipolar && fmt == AIVF_FMT_TWOS)
                                |-> wr_word[W_SIGN] == (CONV_VALUE_I < LIM_ZERO))
    else $error("sign bit wrong on no-overrange variant");
  apb_wait_a: assert property (apb_acc |=> PREADY_O ##1 !PREADY_O)
    else $error("apb ready not a single cycle after one wait");
  irq_level_a: assert property (IRQ_O == |(int_stat & int_mask))
    else $error("interrupt level does not follow unmasked status");
endmodule

// [testbench/aivf_conv_model.sv]
`timescale 1ns/100ps
module aivf_conv_model (
  input  wire logic                        clk_i,
  input  wire logic                        cmd_i,
  input  wire logic [aivf_pkg::CH_W-1:0]   cmd_ch_i,
  input  wire logic [aivf_pkg::VAL_W-1:0]  val_i,
  input  wire logic                        wire_i,
  input  wire logic [7:0]                  delay_i,
  input  wire logic                        scan_req_i,
  input  wire logic [aivf_pkg::CH_W-1:0]   scan_ch_i,
  output logic                             done_o,
  output logic      [aivf_pkg::CH_W-1:0]   ch_o,
  output logic      [aivf_pkg::VAL_W-1:0]  val_o,
  output logic                             wire_o
);
  import aivf_pkg::*;
  int              cnt = 0;
  logic [CH_W-1:0] sch = '0;
  initial begin
    done_o = 1'b0;
    ch_o = '0;
    val_o = '0;
    wire_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (cmd_i || cnt == 1) begin
      done_o <= 1'b1;
      ch_o <= cmd_i ? cmd_ch_i : sch;
      val_o <= val_i;
      wire_o <= wire_i;
    end else begin
      done_o <= 1'b0;
      // junk between results so nothing reads stale values
      ch_o <= ~ch_o;
      val_o <= ~val_o;
      wire_o <= ~wire_o;
    end
    if (scan_req_i) begin
      cnt <= delay_i + 1;
      sch <= scan_ch_i;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// [testbench/tb_aivf_top.sv]
`timescale 1ns/100ps
module tb_aivf_top;
  import aivf_pkg::*;
  logic SYS_CLK_I, RSTN_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O, IRQ_O;
  logic CONV_DONE_I, CONV_WIRE_BREAK_I, SCAN_REQ_O, cmd, wb;
  logic [7:0] PADDR_I, dly;
  logic [31:0] PWDATA_I, PRDATA_O, rd;
  logic [3:0] CONV_CH_I, SCAN_CH_O, cch, stat;
  logic signed [13:0] CONV_VALUE_I, val;
  logic [15:0] mem [16];
  logic [15:0] pend;
  logic er;
  int mismatches = 0, tests_run = 0, seed = 32'h53dcb391, ctl = 0, v, c, n;
  int nreq = 0;
  int cf [10] = '{0, 2, 4, 6, 1, 3, 5, 7, 8, 9};
  int vl [11] = '{0, 1, -1, 2047, 2048, -2048, -2049, 4095, 4096, -4096, -5000};
  aivf_top u_aivf_top (.SYS_CLK_I, .RSTN_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
    .PRDATA_O, .PREADY_O, .PSLVERR_O, .CONV_DONE_I, .CONV_CH_I, .CONV_VALUE_I, .CONV_WIRE_BREAK_I,
    .SCAN_REQ_O, .SCAN_CH_O, .IRQ_O);
  aivf_conv_model u_aivf_conv_model (.clk_i(SYS_CLK_I), .cmd_i(cmd), .cmd_ch_i(cch), .val_i(val),
    .wire_i(wb), .delay_i(dly), .scan_req_i(SCAN_REQ_O), .scan_ch_i(SCAN_CH_O), .done_o(CONV_DONE_I),
    .ch_o(CONV_CH_I), .val_o(CONV_VALUE_I), .wire_o(CONV_WIRE_BREAK_I));
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_word(int k, int x, logic w);
    int f, lo, hi, m;
    logic [15:0] r;
    f = (k >> 1) & 3;
    if (f == 3) f = 0;
    lo = -4095;
    hi = 4095;
    if ((k & 8) != 0) lo = 0;
    else if (f == 2 || (k & 1) != 0) begin
      lo = (f == 1) ? -2047 : -2048;
      hi = 2047;
    end
    m = x < lo ? lo : (x > hi ? hi : x);
    if ((k & 8) != 0) r = 16'(m * 8);
    else if (f == 2) r = 16'((m + 2048) * 8);
    else if (f == 1) r = {m < 0, 15'((m < 0 ? -m : m) * 8)};
    else if ((k & 1) != 0) r = {m < 0, 15'((m & 2047) * 8)};
    else r = 16'(m * 8);
    r[0] = (x != m);
    r[1] = w;
    return r;
  endfunction
  task end_sim;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    PSEL_I <= 1'b1;
    PENABLE_I <= 1'b0;
    PWRITE_I <= wr;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge SYS_CLK_I);
    PENABLE_I <= 1'b1;
    do begin
      @(posedge SYS_CLK_I);
      k++;
    end while (PREADY_O !== 1'b1 && k < 16);
    rd = PRDATA_O;
    er = PSLVERR_O;
    if (k >= 16) begin
      mismatches++;
      end_sim();
    end
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    @(posedge SYS_CLK_I);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task conv(input int ch, input int x, input logic w);
    cmd <= 1'b1;
    cch <= ch[3:0];
    val <= x[13:0];
    wb <= w;
    @(posedge SYS_CLK_I);
    cmd <= 1'b0;
    repeat (2) @(posedge SYS_CLK_I);
    mem[ch] = exp_word(ctl, x, w);
    stat = stat | {1'b0, w, mem[ch][0], 1'b1};
  endtask
  function automatic logic [31:0] rv(int ch);
    return {16'h0, mem[ch] | {pend[ch], 2'b00}};
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    SYS_CLK_I = 1'b0;
    forever #20 SYS_CLK_I = ~SYS_CLK_I;
  end
  always @(posedge SYS_CLK_I) begin
    if (SCAN_REQ_O === 1'b1) begin
      nreq <= nreq + 1;
    end
  end
  initial begin
    repeat (100000) @(posedge SYS_CLK_I);
    mismatches++;
    end_sim();
  end
  initial begin
    {RSTN_I, PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I, cmd, cch, val, wb, dly} = '0;
    pend = '0;
    stat = '0;
    repeat (6) @(posedge SYS_CLK_I);
    RSTN_I <= 1'b1;
    @(posedge SYS_CLK_I);
    rchk(OFS_CTRL, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, OFS_DATA, 32'hffff);
    chk(er, 1'b1);
    apb(1'b1, OFS_INT_MASK, 32'h0);
    conv(0, 5000, 1'b1);
    chk(IRQ_O, 1'b0);
    rchk(OFS_INT_STAT, 32'h7);
    apb(1'b1, OFS_INT_MASK, 32'h2);
    repeat (2) @(posedge SYS_CLK_I);
    chk(IRQ_O, 1'b1);
    apb(1'b1, OFS_INT_STAT, 32'hf);
    @(posedge SYS_CLK_I);
    chk(IRQ_O, 1'b0);
    stat = '0;
    for (int k = 0; k < 10; k++) begin
      ctl = cf[k];
      apb(1'b1, OFS_CTRL, 32'(ctl));
      for (int j = 0; j < 12; j++) begin
        v = (j < 11) ? vl[j] : $random(seed) % 5000;
        c = (k * 12 + j) % 16;
        conv(c, v, 1'($random(seed)));
        rchk(OFS_DATA + 8'(4 * c), rv(c));
        if (k + j > 0) rchk(OFS_DATA + 8'(4 * ((c + 15) % 16)), rv((c + 15) % 16));
      end
    end
    rchk(OFS_INT_STAT, 32'(stat));
    // single scan with a slow converter
    ctl = 32'h10;
    apb(1'b1, OFS_CTRL, 32'h10);
    apb(1'b1, OFS_INT_STAT, 32'hf);
    dly <= 8'd30;
    val <= 14'd100;
    wb <= 1'b0;
    apb(1'b1, OFS_SCAN, 32'h105);
    pend[5] = 1'b1;
    chk(SCAN_CH_O, 4'h5);
    rchk(OFS_PEND, 32'h20);
    rchk(OFS_DATA + 8'd20, rv(5));
    n = 0;
    while (CONV_DONE_I !== 1'b1 && n < 100) begin
      @(posedge SYS_CLK_I);
      n++;
    end
    chk(n < 100, 1'b1);
    @(posedge SYS_CLK_I);
    mem[5] = exp_word(ctl, 100, 1'b0);
    pend[5] = 1'b0;
    rchk(OFS_PEND, 32'h0);
    rchk(OFS_DATA + 8'd20, rv(5));
    rchk(OFS_INT_STAT, 32'h9);
    apb(1'b1, OFS_CTRL, 32'h11);
    apb(1'b1, OFS_SCAN, 32'h105);
    rchk(OFS_PEND, 32'h0);
    chk(nreq, 1);
    end_sim();
  end
endmodule
